// [pkg/spwm_params.svh]
/*
 * constants of the six-output pulse modulator: offsets, fields, resets.
 * assumes byte addresses on a 32-bit wishbone with word-aligned registers.
 */
`ifndef SPWM_PARAMS_SVH
`define SPWM_PARAMS_SVH

`define SPWM_ADR_CONTROL     8'h00
`define SPWM_ADR_WORD_FIRST  8'h04
`define SPWM_ADR_WORD_LAST   8'h30
`define SPWM_ADR_IRQ_CLEAR   8'h34
`define SPWM_ADR_STATUS      8'h38
`define SPWM_ADR_COUNT0      8'h3c

`define SPWM_CTRL_RESET      16'h0012

`define SPWM_BIT_SYNC        14
`define SPWM_BIT_INV5        13
`define SPWM_BIT_INV3        12
`define SPWM_BIT_INV1        11
`define SPWM_BIT_TRIP        10
`define SPWM_BIT_DRIVE_ON    9
`define SPWM_BIT_DIV_HI      8
`define SPWM_BIT_DIV_LO      6
`define SPWM_BIT_ALL_FLIP    5
`define SPWM_BIT_HS_OFF      4
`define SPWM_BIT_LCOMP       3
`define SPWM_BIT_DIR         2
`define SPWM_BIT_BRIDGE      1
`define SPWM_BIT_GLOBAL_ON   0

`define SPWM_WORDS           12
`define SPWM_WORD_RESET      16'h0000
`define SPWM_SEL_LEN         2'h3

`endif

// [pkg/spwm_pkg.sv]
/*
 * types of the six-output pulse modulator.
 * assumes the constants header is included where numbers are needed.
 */
package spwm_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_LATCH,
    BUS_ACK
  } spwm_bus_t;

  typedef logic [15:0] spwm_word_t;
  typedef logic [3:0]  spwm_idx_t;

endpackage

// [src/spwm_word_mem.sv]
/*
 * word store for the compare and period values, one write port,
 * two read ports, each read data registered.
 * assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "spwm_params.svh"

module spwm_word_mem
  import spwm_pkg::*;
#(
  parameter int WORDS = `SPWM_WORDS
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire spwm_idx_t  wadr_i,
  input  wire spwm_word_t wdat_i,
  input  wire spwm_idx_t  radr_a_i,
  output spwm_word_t      rdat_a_o,
  input  wire spwm_idx_t  radr_b_i,
  output spwm_word_t      rdat_b_o
);

  spwm_word_t mem_reg [WORDS];
  spwm_word_t rdat_a_reg;
  spwm_word_t rdat_b_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_reg[i] <= `SPWM_WORD_RESET;
      end
    end else if (we_i) begin
      mem_reg[wadr_i] <= wdat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_a_reg <= `SPWM_WORD_RESET;
      rdat_b_reg <= `SPWM_WORD_RESET;
    end else begin
      rdat_a_reg <= mem_reg[radr_a_i];
      rdat_b_reg <= mem_reg[radr_b_i];
    end
  end

  assign rdat_a_o = rdat_a_reg;
  assign rdat_b_o = rdat_b_reg;

endmodule

// [src/spwm_top.sv]
/*
 * six-output pulse modulator with h-bridge mode, wishbone slave.
 * assumes clk_i is the undivided core clock; align and trip pins are async.
 */
`timescale 1ns/10ps
`include "spwm_params.svh"

module spwm_top
  import spwm_pkg::*;
#(
  parameter int PAIRS = 3,
  parameter int WORDS = `SPWM_WORDS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        external_align_input_i,
  input  wire logic [1:0]  fault_trip_n_i,
  output logic [5:0]       pwm_o,
  output logic             trip_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] div_mask(input logic [2:0] sel);
    div_mask = 8'((9'h002 << sel) - 9'h001);
  endfunction

  function automatic spwm_idx_t word_index(input logic [7:0] adr);
    logic [7:0] off;
    off = adr - `SPWM_ADR_WORD_FIRST;
    word_index = off[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic       align_s1_reg;
  logic       align_s2_reg;
  logic       align_prev_reg;
  logic [1:0] trip_s1_reg;
  logic [1:0] trip_s2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      align_s1_reg   <= 1'b1;
      align_s2_reg   <= 1'b1;
      align_prev_reg <= 1'b1;
      trip_s1_reg    <= 2'h3;
      trip_s2_reg    <= 2'h3;
    end else begin
      align_s1_reg   <= external_align_input_i;
      align_s2_reg   <= align_s1_reg;
      align_prev_reg <= align_s2_reg;
      trip_s1_reg    <= fault_trip_n_i;
      trip_s2_reg    <= trip_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  spwm_bus_t   bus_state_reg;
  spwm_bus_t   bus_state_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        pend_reg;
  logic [15:0] cnt_reg [PAIRS];
  spwm_word_t  mem_rdat_a;

  wire logic req      = wb_cyc_i && wb_stb_i;
  wire logic hit_ctrl = wb_adr_i == `SPWM_ADR_CONTROL;
  wire logic hit_word = wb_adr_i >= `SPWM_ADR_WORD_FIRST &&
                        wb_adr_i <= `SPWM_ADR_WORD_LAST &&
                        wb_adr_i[1:0] == 2'h0;
  wire logic hit_clr  = wb_adr_i == `SPWM_ADR_IRQ_CLEAR;
  wire logic hit_stat = wb_adr_i == `SPWM_ADR_STATUS;
  wire logic hit_cnt  = wb_adr_i == `SPWM_ADR_COUNT0;
  wire logic wr_fire  = bus_state_reg == BUS_ACK && req && wb_we_i;
  wire logic wr_ctrl  = wr_fire && hit_ctrl;
  wire logic wr_word  = wr_fire && hit_word && wb_sel_i[1:0] == 2'h3;
  wire logic wr_clr   = wr_fire && hit_clr;
  wire spwm_idx_t bus_idx = word_index(wb_adr_i);

  // byte lanes merged into the control word
  wire logic [15:0] ctrl_wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [15:0] ctrl_wdat  = (ctrl_reg & ~ctrl_wmask) |
                                 (wb_dat_i[15:0] & ctrl_wmask);

  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (req) begin
          bus_state_next = BUS_LATCH;
        end
      end
      BUS_LATCH: begin
        bus_state_next = BUS_ACK;
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    dat_next = 32'h0000_0000;
    if (hit_ctrl) begin
      dat_next = {16'h0000, ctrl_reg};
    end else if (hit_word) begin
      dat_next = {16'h0000, mem_rdat_a};
    end else if (hit_stat) begin
      dat_next = {31'h0000_0000, pend_reg};
    end else if (hit_cnt) begin
      dat_next = {16'h0000, cnt_reg[0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= BUS_IDLE;
      dat_reg       <= 32'h0000_0000;
    end else begin
      bus_state_reg <= bus_state_next;
      if (bus_state_reg == BUS_LATCH) begin
        dat_reg <= dat_next;
      end
    end
  end

  assign wb_ack_o = bus_state_reg == BUS_ACK && req;
  assign wb_dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // control register and trip

  wire logic trip_low  = trip_s2_reg != 2'h3;
  wire logic trip_fire = ctrl_reg[`SPWM_BIT_TRIP] && trip_low;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = ctrl_wdat;
    end
    if (trip_fire) begin
      ctrl_next[`SPWM_BIT_GLOBAL_ON] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SPWM_CTRL_RESET;
      pend_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (trip_fire) begin
        pend_reg <= 1'b1;
      end else if (wr_clr) begin
        pend_reg <= 1'b0;
      end
    end
  end

  assign trip_irq_o = pend_reg;

  ////////////////////////////////////////////////////////////////////////////
  // word store and sweep into active registers

  spwm_idx_t   seq_idx_reg;
  spwm_idx_t   seq_got_reg;
  logic        armed_reg;
  logic        loading_reg;
  spwm_word_t  mem_rdat_b;
  logic [15:0] act_reg [PAIRS][4];

  spwm_word_mem #(
    .WORDS(WORDS)
  ) u_mem (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .we_i     (wr_word),
    .wadr_i   (bus_idx),
    .wdat_i   (wb_dat_i[15:0]),
    .radr_a_i (bus_idx),
    .rdat_a_o (mem_rdat_a),
    .radr_b_i (seq_idx_reg),
    .rdat_b_o (mem_rdat_b)
  );

  wire logic [1:0] got_sel  = seq_got_reg[1:0];
  wire logic [1:0] got_pair = seq_got_reg[3:2];
  wire logic       seq_wrap = seq_got_reg == 4'(WORDS - 1);
  wire logic       tick;
  wire logic       sync_fire;
  wire logic       first_step = tick && !sync_fire &&
                                cnt_reg[0] == 16'h0000 && act_reg[0][3] != 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_idx_reg <= 4'h0;
      seq_got_reg <= 4'h0;
      armed_reg   <= 1'b0;
      loading_reg <= 1'b0;
      for (int p = 0; p < PAIRS; p++) begin
        for (int s = 0; s < 4; s++) begin
          act_reg[p][s] <= `SPWM_WORD_RESET;
        end
      end
    end else begin
      seq_idx_reg <= (seq_idx_reg == 4'(WORDS - 1)) ? 4'h0 : seq_idx_reg + 4'h1;
      seq_got_reg <= seq_idx_reg;
      if (first_step && ctrl_reg[`SPWM_BIT_LCOMP]) begin
        armed_reg <= 1'b1;
      end else if (seq_wrap) begin
        armed_reg <= 1'b0;
      end
      if (seq_wrap) begin
        loading_reg <= armed_reg;
      end
      if (got_sel == `SPWM_SEL_LEN || loading_reg) begin
        act_reg[got_pair][got_sel] <= mem_rdat_b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and timers

  logic [7:0] pre_reg;
  wire  [2:0] div_sel = ctrl_reg[`SPWM_BIT_DIV_HI:`SPWM_BIT_DIV_LO];

  assign sync_fire = ctrl_reg[`SPWM_BIT_SYNC] &&
                     align_prev_reg && !align_s2_reg;
  assign tick      = (pre_reg & div_mask(div_sel)) == div_mask(div_sel);

  always_ff @(posedge clk_i) begin
    if (rst_i || sync_fire) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  logic [PAIRS-1:0] hi_reg;
  logic [PAIRS-1:0] lo_reg;
  logic [PAIRS-1:0] hi_next;
  logic [PAIRS-1:0] lo_next;

  always_comb begin
    for (int p = 0; p < PAIRS; p++) begin
      hi_next[p] = hi_reg[p];
      if (cnt_reg[p] == act_reg[p][1]) begin
        hi_next[p] = 1'b0;
      end else if (cnt_reg[p] == act_reg[p][0]) begin
        hi_next[p] = 1'b1;
      end
      lo_next[p] = lo_reg[p];
      if (cnt_reg[p] == act_reg[p][2] || (hi_reg[p] && !hi_next[p])) begin
        lo_next[p] = 1'b0;
      end else if (cnt_reg[p] == act_reg[p][3]) begin
        lo_next[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_reg <= '0;
      lo_reg <= '0;
      for (int p = 0; p < PAIRS; p++) begin
        cnt_reg[p] <= 16'h0000;
      end
    end else begin
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      for (int p = 0; p < PAIRS; p++) begin
        if (sync_fire) begin
          cnt_reg[p] <= 16'h0000;
        end else if (tick) begin
          cnt_reg[p] <= (cnt_reg[p] >= act_reg[p][3]) ? 16'h0000 :
                        cnt_reg[p] + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output selection

  wire logic [5:0] raw  = {lo_reg[2], hi_reg[2], lo_reg[1], hi_reg[1], lo_reg[0], hi_reg[0]};
  wire logic [5:0] flip = {ctrl_reg[`SPWM_BIT_INV5], 1'b0, ctrl_reg[`SPWM_BIT_INV3],
                           1'b0, ctrl_reg[`SPWM_BIT_INV1], 1'b0};
  wire logic       en   = ctrl_reg[`SPWM_BIT_GLOBAL_ON];
  wire logic [5:0] std  = en ? (raw ^ flip) : 6'h00;
  wire logic       hs   = raw[0];
  wire logic       ls   = raw[1] ^ flip[1];
  wire logic       hs_off = ctrl_reg[`SPWM_BIT_HS_OFF];
  wire logic       drive_on = ctrl_reg[`SPWM_BIT_DRIVE_ON] && en;
  wire logic [1:0] pick = {ctrl_reg[`SPWM_BIT_ALL_FLIP], ctrl_reg[`SPWM_BIT_DIR]};
  logic [3:0]      hb;
  logic [5:0]      pwm_reg;

  always_comb begin
    hb = 4'hf;
    if (hs_off) begin
      hb = 4'h5;
    end else if (drive_on) begin
      case (pick)
        2'h0:    hb = {ls, hs, 2'h0};
        2'h1:    hb = {2'h0, ls, hs};
        2'h2:    hb = {2'h3, ls, hs};
        default: hb = {ls, hs, 2'h3};
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_reg <= 6'h05;
    end else if (ctrl_reg[`SPWM_BIT_BRIDGE]) begin
      pwm_reg <= {std[5:4], hb};
    end else begin
      pwm_reg <= std;
    end
  end

  assign pwm_o = pwm_reg;

endmodule

// [tb/spwm_stage_model.sv]
/*
 * power stage model: measures period and high time of each output, drives trip pins.
 * assumes outputs settle between rising edges of clk_i.
 */
`timescale 1ns/10ps

module spwm_stage_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] pwm_i,
  input  wire logic [1:0] fault_i,
  output logic [1:0]      trip_n_o,
  output logic [15:0]     per_o [6],
  output logic [15:0]     hi_o [6]
);
  logic [5:0]  q_reg;
  logic [15:0] run_reg [6];
  logic [15:0] hc_reg [6];

  // trip pins pulled high, pulled low only while a fault is requested
  assign trip_n_o = ~fault_i;

  always_ff @(posedge clk_i) begin
    q_reg <= pwm_i;
    for (int i = 0; i < 6; i++) begin
      if (pwm_i[i] && !q_reg[i]) begin
        per_o[i]   <= run_reg[i];
        hi_o[i]    <= hc_reg[i];
        run_reg[i] <= 16'h0001;
        hc_reg[i]  <= 16'h0001;
      end else begin
        run_reg[i] <= run_reg[i] + 16'h0001;
        hc_reg[i]  <= hc_reg[i] + {15'h0000, pwm_i[i]};
      end
    end
  end
endmodule

// [tb/spwm_properties.sv]
/*
 * port assertions of the pulse modulator, bound into spwm_top.
 * assumes control writes enable byte lanes 0 and 1.
 */
`timescale 1ns/10ps
`include "spwm_params.svh"

module spwm_chk
  import spwm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  fault_trip_n_i,
  input wire logic [5:0]  pwm_o,
  input wire logic        trip_irq_o
);
  spwm_word_t ctl_reg;
  logic [3:0] age_reg;
  logic       irq_q_reg;
  wire        ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == `SPWM_ADR_CONTROL
                       && wb_sel_i[1:0] == 2'h3;
  wire        clr_wr = wb_ack_o && wb_we_i && wb_adr_i == `SPWM_ADR_IRQ_CLEAR;
  wire        irq_up = trip_irq_o && !irq_q_reg;
  wire        calm   = age_reg > 4'h6;
  wire        hb     = calm && ctl_reg[1] && !ctl_reg[4];

  // shadow of control, with the enable bit dropped when a trip is taken
  always_ff @(posedge clk_i) begin
    irq_q_reg <= rst_i ? 1'b0 : trip_irq_o;
    if (rst_i) begin
      ctl_reg <= `SPWM_CTRL_RESET;
      age_reg <= 4'h0;
    end else if (ctl_wr || irq_up) begin
      ctl_reg <= ctl_wr ? wb_dat_i[15:0] : ctl_reg & 16'hfffe;
      age_reg <= 4'h0;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack high two cycles");
  chk_reset_state: assert property ($fell(rst_i) |-> pwm_o == 6'h05 && !trip_irq_o)
    else $error("outputs wrong after reset");
  chk_high_side_off_force: assert property (calm && ctl_reg[1] && ctl_reg[4] |-> pwm_o[3:0] == 4'h5)
    else $error("high side off not forced");
  chk_bridge_off: assert property (hb && !(ctl_reg[9] && ctl_reg[0]) |-> pwm_o[3:0] == 4'hf)
    else $error("disabled bridge not all high");
  chk_bridge_idle: assert property (hb && ctl_reg[9] && ctl_reg[0] && !trip_irq_o
    |-> (ctl_reg[5] == ctl_reg[2] ? pwm_o[1:0] : pwm_o[3:2]) == {2{ctl_reg[5]}})
    else $error("idle bridge pair wrong");
  chk_trip_raise: assert property (calm && ctl_reg[10] && fault_trip_n_i != 2'b11
    |-> ##[1:5] trip_irq_o)
    else $error("trip not raised");
  chk_trip_quiet: assert property (calm && !ctl_reg[10] |-> !$rose(trip_irq_o))
    else $error("trip raised while disabled");
  chk_irq_hold: assert property (trip_irq_o && !clr_wr |=> trip_irq_o)
    else $error("trip pending lost without clear");
endmodule

bind spwm_top spwm_chk u_chk (
  .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .fault_trip_n_i, .pwm_o, .trip_irq_o
);

// [tb/spwm_top_tb.sv]
/*
 * bench of the pulse modulator: wishbone tasks and call sequences.
 * assumes the stage model and the bound checker are compiled first.
 */
`timescale 1ns/10ps
`include "spwm_params.svh"

module spwm_top_tb
  import spwm_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        align;
  logic [1:0]  fault_req;
  logic [1:0]  trip_n;
  logic [5:0]  pwm;
  logic        irq;
  logic [15:0] per [6];
  logic [15:0] hi [6];
  spwm_word_t  got;
  int          errors;
  int          n_compared;

  spwm_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_align_input_i(align), .fault_trip_n_i(trip_n), .pwm_o(pwm), .trip_irq_o(irq)
  );

  spwm_stage_model u_stage (
    .clk_i(clk_i), .pwm_i(pwm), .fault_i(fault_req), .trip_n_o(trip_n), .per_o(per), .hi_o(hi)
  );

  ////////////////////////////////////////////////////////////
  task automatic nap(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input spwm_word_t d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 40);
    got = rdat[15:0];
    if (t >= 40) errors++;
    cyc <= 1'b0;
  endtask

  task automatic cmp_val(input spwm_word_t g, input spwm_word_t e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] a, input spwm_word_t e);
    xfer(1'b0, a, 16'h0000);
    cmp_val(got, e);
  endtask

  task automatic report_and_stop();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial begin
    rst_i      = 1'b1;
    cyc        = 1'b0;
    we         = 1'b0;
    adr        = 8'h00;
    wdat       = 32'h0;
    align      = 1'b1;
    fault_req  = 2'b00;
    errors     = 0;
    n_compared = 0;
    nap(12);
    rst_i <= 1'b0;
    nap(1);
    cmp_val({10'h0, pwm}, 16'h0005);
    cmp_reg(`SPWM_ADR_CONTROL, `SPWM_CTRL_RESET);
    cmp_reg(8'h04, `SPWM_WORD_RESET);
    cmp_reg(8'h80, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      xfer(1'b1, 8'(4 + 16 * p), 16'd2);
      xfer(1'b1, 8'(8 + 16 * p), 16'd6);
      xfer(1'b1, 8'(12 + 16 * p), 16'd1);
      xfer(1'b1, 8'(16 + 16 * p), 16'(9 + 2 * p));
    end
    cmp_reg(8'h30, 16'd13);
    for (int v = 0; v < 2; v++) begin
      xfer(1'b1, `SPWM_ADR_CONTROL, v == 1 ? 16'h3809 : 16'h0009);
      nap(200);
      for (int i = 0; i < 6; i++) begin
        cmp_val(per[i], 16'(20 + 4 * (i / 2)));
        cmp_val(hi[i], i % 2 == 0 ? 16'd8 : (v == 1 ? 16'(16 + 4 * (i / 2)) : 16'd4));
      end
    end
    for (int s = 0; s < 8; s++) begin
      xfer(1'b1, `SPWM_ADR_CONTROL, 16'h0009 | {6'h0, s[0], s[2:0], 6'h0});
      nap(40 << (s + 1));
      cmp_val(per[0], 16'd10 << (s + 1));
      cmp_val(hi[0], 16'd4 << (s + 1));
    end
    xfer(1'b1, 8'h10, 16'h0fff);
    for (int v = 0; v < 2; v++) begin
      xfer(1'b1, `SPWM_ADR_CONTROL, v == 1 ? 16'h0009 : 16'h4009);
      nap(300);
      align <= 1'b0;
      nap(8);
      xfer(1'b0, `SPWM_ADR_COUNT0, 16'h0000);
      cmp_val({15'h0, got < 16'h0010}, v == 1 ? 16'h0000 : 16'h0001);
      align <= 1'b1;
    end
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: xfer(1'b1, `SPWM_ADR_CONTROL, `SPWM_CTRL_RESET);
        1: xfer(1'b1, `SPWM_ADR_CONTROL, 16'h0002);
        2: xfer(1'b1, `SPWM_ADR_CONTROL, 16'h0202);
        default: xfer(1'b1, `SPWM_ADR_CONTROL, 16'h0203 | {10'h0, k[1], 2'h0, k[0], 2'h0});
      endcase
      nap(12);
      if (k < 3) cmp_val({12'h0, pwm[3:0]}, k == 0 ? 16'h0005 : 16'h000f);
      else cmp_val({14'h0, k[1] == k[0] ? pwm[1:0] : pwm[3:2]}, k[1] ? 16'h0003 : 16'h0000);
    end
    xfer(1'b1, `SPWM_ADR_CONTROL, 16'h0409);
    nap(10);
    fault_req <= 2'b10;
    nap(10);
    cmp_val({15'h0, irq}, 16'h0001);
    cmp_reg(`SPWM_ADR_CONTROL, 16'h0408);
    fault_req <= 2'b00;
    nap(20);
    cmp_val({15'h0, irq}, 16'h0001);
    cmp_reg(`SPWM_ADR_STATUS, 16'h0001);
    xfer(1'b1, `SPWM_ADR_IRQ_CLEAR, 16'h0000);
    nap(3);
    cmp_val({15'h0, irq}, 16'h0000);
    xfer(1'b1, `SPWM_ADR_CONTROL, 16'h0009);
    fault_req <= 2'b01;
    nap(20);
    cmp_val({15'h0, irq}, 16'h0000);
    report_and_stop();
  end
endmodule
